// >>> src/tto_port.v
// Output stage of the timing and trigger receiver
`include "tto_defs.vh"

module tto_port
#(
   parameter CDEPTH = 16,    // Coarse delay taps
   parameter FDEPTH = 16,    // Fine deskew taps in system cycles
   parameter BWIDTH = 20,    // Buffer word: qualifier, sub-address, data
   parameter BDEPTH = 2      // Buffer entries
)
(
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        ref_clock_i,
   input  wire        lock_i,
   input  wire [7:0]  control_i,
   input  wire [7:0]  coarse_delay_i,
   input  wire [3:0]  fine_delay_one_i,
   input  wire [3:0]  fine_delay_two_i,
   input  wire        serial_b_en_i,
   input  wire        serial_b_i,
   input  wire        trigger_i,
   input  wire        event_reset_i,
   input  wire        bunch_reset_i,
   input  wire        broadcast_valid_i,
   input  wire [7:2]  broadcast_i,
   input  wire [11:0] bunch_count_i,
   input  wire [23:0] event_count_i,
   input  wire        single_error_i,
   input  wire        double_error_i,
   input  wire        iac_valid_i,
   input  wire [7:0]  iac_data_i,
   input  wire [7:0]  iac_subaddr_i,
   input  wire [3:0]  iac_qual_i,
   output wire        iac_ready_o,
   input  wire        data_hold_i,
   output reg  [11:0] counter_output_bus_o,
   output reg         bunch_count_strobe_o,
   output reg         event_low_word_strobe_o,
   output reg         event_high_word_strobe_o,
   output reg         trigger_accept_out_o,
   output reg         event_count_reset_out_o,
   output reg         bunch_count_reset_out_o,
   output reg  [7:2]  broadcast_o,
   output reg         broadcast_strobe_one_o,
   output reg         broadcast_strobe_two_o,
   output reg  [7:0]  data_out_o,
   output wire        data_out_oe_o,
   output reg  [7:0]  sub_address_bus_o,
   output wire        sub_address_bus_oe_o,
   input  wire [7:0]  sub_address_bus_i,
   output reg  [3:0]  data_qualifier_o,
   output reg         data_out_strobe_o,
   output reg         single_error_strobe_o,
   output reg         double_error_strobe_o,
   output reg         serial_b_copy_o,
   output reg         receiver_ready_out_o,
   output wire        reference_clock_out_o,
   output wire        deskewed_clock_one_o,
   output wire        deskewed_clock_two_o,
   output wire        clock_with_trigger_gap_o,
   output reg         prom_enable_reset_pin_o,
   output reg         prom_enable_reset_pin_oe_o,
   input  wire        prom_enable_reset_pin_i,
   output reg         prom_load_enable_o,
   output reg  [7:0]  chip_identifier_upper_o
);

   // Trigger sequence states
   localparam ST_IDLE  = 2'h0;
   localparam ST_BUNCH = 2'h1;
   localparam ST_EVLO  = 2'h2;
   localparam ST_EVHI  = 2'h3;

   // Qualifier range check
   function qual_ok;
      input [3:0] q;
      begin
         qual_ok = (q == `TTO_QUAL_CMD) ||
                   ((q >= `TTO_QUAL_DUMP_FIRST) && (q <= `TTO_QUAL_DUMP_LAST));
      end
   endfunction

   integer k;

   reg              ref_m;
   reg              ref_s;
   reg              ref_d;
   reg              hold_m;
   reg              hold_s;
   reg  [7:0]       sa_m;
   reg  [7:0]       sa_s;
   reg              pr_m;
   reg              pr_s;
   reg              rst_d;
   reg  [FDEPTH-1:0] fine_sh;
   reg              clk1_d;
   reg              clk2_d;
   reg  [7:0]       pend1;
   reg  [2:0]       pend2;
   reg  [7:0]       dl1 [0:CDEPTH-1];
   reg  [2:0]       dl2 [0:CDEPTH-1];
   reg              err1_p;
   reg              err2_p;
   reg              gap;
   reg  [1:0]       state;
   reg  [1:0]       mode;
   reg  [11:0]      bunch_lat;
   reg  [23:0]      event_lat;
   reg  [BWIDTH-1:0] buf_mem [0:BDEPTH-1];
   reg              wr_ptr;
   reg              rd_ptr;
   reg  [1:0]       count;
   reg  [7:0]       prom_cnt;

   wire             clk1_int;
   wire             clk2_int;
   wire             tick1;
   wire             tick2;
   wire             btick;
   wire             tick_g2;
   wire [7:0]       ev1;
   wire [2:0]       ev2;
   wire [7:0]       tap1;
   wire [2:0]       tap2;
   wire             buf_wr;
   wire             buf_rd;
   wire [BWIDTH-1:0] buf_head;

   // Two-flop synchronisers
   always @(posedge clk_i)
   begin
      ref_m  <= ref_clock_i;
      ref_s  <= ref_m;
      hold_m <= data_hold_i;
      hold_s <= hold_m;
      sa_m   <= sub_address_bus_i;
      sa_s   <= sa_m;
      pr_m   <= prom_enable_reset_pin_i;
      pr_s   <= pr_m;
   end

   // Reference edge history and deskew line
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ref_d   <= 1'b0;
         fine_sh <= {FDEPTH{1'b0}};
         clk1_d  <= 1'b0;
         clk2_d  <= 1'b0;
      end
      else
      begin
         ref_d   <= ref_s;
         fine_sh <= {fine_sh[FDEPTH-2:0], ref_s};
         clk1_d  <= clk1_int;
         clk2_d  <= clk2_int;
      end
   end

   // R2 fine deskew taps
   assign clk1_int = fine_sh[fine_delay_one_i];
   assign clk2_int = fine_sh[fine_delay_two_i];
   assign btick    = ref_s & ~ref_d;
   assign tick1    = clk1_int & ~clk1_d;
   assign tick2    = clk2_int & ~clk2_d;
   // R14 group two retimed to clock two when selected
   assign tick_g2  = control_i[`TTO_CTRL_SEL_CLK2] ? tick2 : tick1;

   // Clock outputs; the reference copy has no guaranteed phase
   assign reference_clock_out_o    = control_i[`TTO_CTRL_EN_REFCLK] & ref_s;
   assign deskewed_clock_one_o     = clk1_int;
   assign deskewed_clock_two_o     = control_i[`TTO_CTRL_EN_CLK2] & clk2_int;
   // R22 reference clock with trigger gap
   assign clock_with_trigger_gap_o = control_i[`TTO_CTRL_EN_CLKTRG] & ref_s & ~gap;

   // Group event vectors
   assign ev1 = {trigger_i, event_reset_i, bunch_reset_i, broadcast_valid_i,
                 broadcast_i[5:2]};
   assign ev2 = {broadcast_valid_i, broadcast_i[7:6]};

   // R15 coarse delay taps per group
   assign tap1 = dl1[coarse_delay_i[3:0]];
   assign tap2 = dl2[coarse_delay_i[7:4]];

   // Events wait for the next bunch edge
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pend1  <= `TTO_RESET_BYTE;
         pend2  <= 3'h0;
         err1_p <= 1'b0;
         err2_p <= 1'b0;
         gap    <= 1'b0;
         for (k = 0; k < CDEPTH; k = k + 1)
         begin
            dl1[k] <= `TTO_RESET_BYTE;
            dl2[k] <= 3'h0;
         end
      end
      else
      begin
         pend1  <= btick ? 8'h00 : (ev1 | pend1);
         pend2  <= btick ? 3'h0 : (ev2 | pend2);
         // R8 errors held until the next clock-one edge
         err1_p <= (single_error_i | err1_p) & ~tick1;
         err2_p <= (double_error_i | err2_p) & ~tick1;
         if (btick)
         begin
            // R15 one coarse unit per bunch period
            dl1[0] <= pend1 | ev1;
            dl2[0] <= pend2 | ev2;
            for (k = 1; k < CDEPTH; k = k + 1)
            begin
               dl1[k] <= dl1[k-1];
               dl2[k] <= dl2[k-1];
            end
            // R22 gap for one reference period per trigger
            gap <= pend1[7] | trigger_i;
         end
      end
   end

   // R13 group one outputs on clock one
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         trigger_accept_out_o    <= 1'b0;
         event_count_reset_out_o <= 1'b0;
         bunch_count_reset_out_o <= 1'b0;
         broadcast_strobe_one_o  <= 1'b0;
         broadcast_o[5:2]        <= 4'h0;
         single_error_strobe_o   <= 1'b0;
         double_error_strobe_o   <= 1'b0;
      end
      else if (tick1)
      begin
         // R3 delayed trigger accept
         trigger_accept_out_o    <= tap1[7];
         // R2 delayed event count reset
         event_count_reset_out_o <= tap1[6];
         bunch_count_reset_out_o <= tap1[5];
         // R23 strobes last one aligning clock period
         broadcast_strobe_one_o  <= tap1[4];
         if (tap1[4])
            broadcast_o[5:2] <= tap1[3:0];
         // R8 single error strobe
         single_error_strobe_o   <= err1_p | single_error_i;
         double_error_strobe_o   <= err2_p | double_error_i;
      end
   end

   // R14 group two outputs on the selected deskewed clock
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         broadcast_strobe_two_o <= 1'b0;
         broadcast_o[7:6]       <= 2'h0;
      end
      else if (tick_g2)
      begin
         broadcast_strobe_two_o <= tap2[2];
         if (tap2[2])
            broadcast_o[7:6] <= tap2[1:0];
      end
   end

   // R18 trigger sequence; triggers ignored while running
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state                    <= ST_IDLE;
         mode                     <= `TTO_SEQ_NONE;
         bunch_lat                <= 12'h000;
         event_lat                <= 24'h000000;
         counter_output_bus_o     <= 12'h000;
         bunch_count_strobe_o     <= 1'b0;
         event_low_word_strobe_o  <= 1'b0;
         event_high_word_strobe_o <= 1'b0;
      end
      else if (tick1)
      begin
         bunch_count_strobe_o     <= 1'b0;
         event_low_word_strobe_o  <= 1'b0;
         event_high_word_strobe_o <= 1'b0;
         case (state)
            ST_IDLE:
            begin
               if (tap1[7])
               begin
                  mode      <= control_i[`TTO_CTRL_SEQ_HI:`TTO_CTRL_SEQ_LO];
                  bunch_lat <= bunch_count_i;
                  event_lat <= event_count_i;
                  // R19 both counters chain bunch then event words
                  case (control_i[`TTO_CTRL_SEQ_HI:`TTO_CTRL_SEQ_LO])
                     `TTO_SEQ_BUNCH: state <= ST_BUNCH;
                     `TTO_SEQ_BOTH:  state <= ST_BUNCH;
                     `TTO_SEQ_EVENT: state <= ST_EVLO;
                     default:        state <= ST_IDLE;
                  endcase
               end
            end
            ST_BUNCH:
            begin
               // R21 bunch number on the bus
               counter_output_bus_o <= bunch_lat;
               bunch_count_strobe_o <= 1'b1;
               state <= (mode == `TTO_SEQ_BOTH) ? ST_EVLO : ST_IDLE;
            end
            ST_EVLO:
            begin
               // R1 low event word with its strobe
               counter_output_bus_o    <= event_lat[11:0];
               event_low_word_strobe_o <= 1'b1;
               state <= ST_EVHI;
            end
            ST_EVHI:
            begin
               counter_output_bus_o     <= event_lat[23:12];
               event_high_word_strobe_o <= 1'b1;
               state <= ST_IDLE;
            end
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   // R20 only defined qualifiers enter the buffer
   assign iac_ready_o = (count != 2'h2);
   assign buf_wr      = iac_valid_i & iac_ready_o & qual_ok(iac_qual_i);
   // A stall keeps words buffered
   assign buf_rd      = tick1 & ~hold_s & (count != 2'h0);
   assign buf_head    = buf_mem[rd_ptr];

   // Two-entry command buffer
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wr_ptr     <= 1'b0;
         rd_ptr     <= 1'b0;
         count      <= 2'h0;
         buf_mem[0] <= {BWIDTH{1'b0}};
         buf_mem[1] <= {BWIDTH{1'b0}};
      end
      else
      begin
         if (buf_wr)
         begin
            buf_mem[wr_ptr] <= {iac_qual_i, iac_subaddr_i, iac_data_i};
            wr_ptr          <= ~wr_ptr;
         end
         if (buf_rd)
            rd_ptr <= ~rd_ptr;
         if (buf_wr & ~buf_rd)
            count <= count + 2'h1;
         else if (buf_rd & ~buf_wr)
            count <= count - 2'h1;
      end
   end

   // R16 data strobe per presented word
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         data_out_o        <= `TTO_RESET_BYTE;
         sub_address_bus_o <= `TTO_RESET_BYTE;
         data_qualifier_o  <= `TTO_QUAL_CMD;
         data_out_strobe_o <= 1'b0;
      end
      else if (tick1)
      begin
         data_out_strobe_o <= buf_rd;
         if (buf_rd)
         begin
            // R17 payload with its qualifier
            data_qualifier_o  <= buf_head[19:16];
            sub_address_bus_o <= buf_head[15:8];
            data_out_o        <= buf_head[7:0];
         end
      end
   end

   // R9 sub-address bus enable; R10 floating while in reset
   assign sub_address_bus_oe_o = ~rst_i & ~rst_d & control_i[`TTO_CTRL_EN_SUBADDR];
   assign data_out_oe_o        = ~rst_i & ~rst_d & control_i[`TTO_CTRL_EN_DATA];

   // PROM reset pulse after release
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rst_d                      <= 1'b1;
         prom_enable_reset_pin_oe_o <= 1'b0;
         prom_enable_reset_pin_o    <= 1'b0;
         prom_cnt                   <= 8'h00;
      end
      else
      begin
         rst_d <= 1'b0;
         if (rst_d)
         begin
            // R5 pin becomes an output, PROM pulse high
            prom_enable_reset_pin_oe_o <= 1'b1;
            prom_enable_reset_pin_o    <= 1'b1;
            prom_cnt                   <= 8'h01;
         end
         else if (prom_cnt != 8'h00)
         begin
            if (prom_cnt == `TTO_PROM_RST_CYC)
            begin
               prom_enable_reset_pin_o <= 1'b0;
               prom_cnt                <= 8'h00;
            end
            else
               prom_cnt <= prom_cnt + 8'h01;
         end
      end
   end

   // Straps caught at release, kept through reset
   always @(posedge clk_i)
   begin
      if (rst_d & ~rst_i)
      begin
         // R4 resistor level selects PROM loading
         prom_load_enable_o      <= pr_s;
         // R10 identifier upper bits from resistors
         chip_identifier_upper_o <= sa_s;
      end
   end

   // Serial copy and ready flag
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         serial_b_copy_o      <= 1'b0;
         receiver_ready_out_o <= 1'b0;
      end
      else
      begin
         // R6 R7 channel B bits passed unchanged when enabled
         serial_b_copy_o      <= serial_b_en_i & serial_b_i;
         // R11 ready follows lock, low in and just after reset
         receiver_ready_out_o <= lock_i & ~rst_d;
      end
   end

endmodule // tto_port

// >>> src/tto_defs.vh
// Constants for the timing and trigger output port
//
// Functional notes
// R1 - Low event word strobe marks event bits 11:0 on the bus.
// R2 - Event count reset delay: coarse 3:0 plus fine one.
// R3 - Trigger accept delay: coarse 3:0 plus fine one.
// R4 - PROM pin floats in reset; a high level selects PROM loading.
// R5 - After reset the PROM pin drives the PROM reset pulse.
// R6 - Channel B bits copied out unchanged, framing included.
// R7 - Control setting enables the channel B copy; the code uses the separate input serial_b_en_i, not a control_i bit.
// R8 - Single error strobe pulses per corrected single error.
// R9 - Sub-address bus output, enabled by control bit 5.
// R10 - Sub-address bus floats in reset; levels give identifier 15:8.
// R11 - Ready is high only while the receiver works.
// R12 - Receiver samples sync outputs on the deskewed clock edge only.
// R13 - Outputs align to clock one; broadcast 7:6 optionally clock two.
// R14 - Control bit 2 moves broadcast 7:6 and strobe two to clock two.
// R15 - Group one delay coarse 3:0, group two 7:4, one cycle each.
// R16 - Data-out strobe pulses on clock one per new value.
// R17 - Data and sub-address carry the 16-bit payload, qualifier its type.
// R18 - A trigger starts a counter sequence chosen by control 1:0.
// R19 - Control 1:0 at 11 sends bunch count and both event words.
// R20 - Qualifier 0000 is command data, 0001 to 1010 register dumps.
// R21 - Bunch count strobe marks a bunch number on the bus.
// R22 - Clock-with-trigger follows reference, low one cycle per trigger.
// R23 - Every strobe lasts one cycle of its aligning clock.
`ifndef TTO_DEFS_VH
`define TTO_DEFS_VH

// System clock period
`define TTO_CLK_NS          4
// Control setting bit positions
`define TTO_CTRL_SEQ_LO     0
`define TTO_CTRL_SEQ_HI     1
`define TTO_CTRL_SEL_CLK2   2
`define TTO_CTRL_EN_CLK2    3
`define TTO_CTRL_EN_CLKTRG  4
`define TTO_CTRL_EN_SUBADDR 5
`define TTO_CTRL_EN_DATA    6
`define TTO_CTRL_EN_REFCLK  7
// Trigger sequence selections
`define TTO_SEQ_NONE        2'h0
`define TTO_SEQ_BUNCH       2'h1
`define TTO_SEQ_EVENT       2'h2
`define TTO_SEQ_BOTH        2'h3
// Qualifier codes
`define TTO_QUAL_CMD        4'h0
`define TTO_QUAL_DUMP_FIRST 4'h1
`define TTO_QUAL_DUMP_LAST  4'ha
// PROM reset pulse, least length
`define TTO_PROM_RST_NS     400
`define TTO_PROM_RST_CYC    ((`TTO_PROM_RST_NS + `TTO_CLK_NS - 1) / `TTO_CLK_NS)
// Reset values
`define TTO_RESET_BYTE      8'h00

`endif

// >>> tb/tto_port_monitor.sv
// Concurrent checks on the port pins
module tto_port_monitor
(
   input logic       clk_i,
   input logic       rst_i,
   input logic       lock_i,
   input logic [7:0] control_i,
   input logic       serial_b_en_i,
   input logic       serial_b_copy_o,
   input logic       receiver_ready_out_o,
   input logic       trigger_accept_out_o,
   input logic       bunch_count_strobe_o,
   input logic       event_low_word_strobe_o,
   input logic       event_high_word_strobe_o,
   input logic       sub_address_bus_oe_o,
   input logic       data_out_oe_o,
   input logic       clock_with_trigger_gap_o,
   input logic       prom_enable_reset_pin_o,
   input logic       prom_enable_reset_pin_oe_o,
   input logic       prom_load_enable_o,
   input logic [7:0] chip_identifier_upper_o
);
   logic [7:0] rel_cnt;
   logic [5:0] lo_run;

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // Release age and low strobe run length
   always @(posedge clk_i)
   begin
      if (rst_i)
         rel_cnt <= 8'h00;
      else if (rel_cnt != 8'hff)
         rel_cnt <= rel_cnt + 8'h01;
      if (rst_i || !event_low_word_strobe_o)
         lo_run <= 6'h00;
      else if (lo_run != 6'h3f)
         lo_run <= lo_run + 6'h01;
   end

   // Reset must not disable the reset checks
   pins_float_a: assert property (disable iff (1'b0)
      rst_i [*2] |-> !prom_enable_reset_pin_oe_o && !sub_address_bus_oe_o
      && !data_out_oe_o && !receiver_ready_out_o && !trigger_accept_out_o)
      else $error("pin driven in reset");
   prom_pulse_a: assert property (
      rel_cnt inside {[1:99]} |-> prom_enable_reset_pin_oe_o && prom_enable_reset_pin_o)
      else $error("prom pulse missing");
   prom_low_a: assert property (
      rel_cnt >= 8'd102 |-> prom_enable_reset_pin_oe_o && !prom_enable_reset_pin_o)
      else $error("prom pulse too long");
   strap_hold_a: assert property (
      rel_cnt >= 8'd2 |-> $stable(chip_identifier_upper_o) && $stable(prom_load_enable_o))
      else $error("strap value changed");
   ready_follows_a: assert property (
      !$past(rst_i, 2) |-> receiver_ready_out_o == $past(lock_i))
      else $error("ready not following lock");
   subaddr_off_a: assert property (!control_i[5] |-> !sub_address_bus_oe_o)
      else $error("sub-address bus driven");
   serial_off_a: assert property ((!serial_b_en_i) [*3] |-> !serial_b_copy_o)
      else $error("serial copy not off");
   gap_off_a: assert property (!control_i[4] |-> !clock_with_trigger_gap_o)
      else $error("gap clock not off");
   seq_onehot_a: assert property (
      $onehot0({bunch_count_strobe_o, event_low_word_strobe_o, event_high_word_strobe_o}))
      else $error("counter strobes overlap");
   low_len_a: assert property (lo_run <= 6'd17)
      else $error("low word strobe too long");

   trig_seen_c: cover property ($rose(trigger_accept_out_o));
   low_word_c: cover property ($rose(event_low_word_strobe_o));
   prom_done_c: cover property ($fell(prom_enable_reset_pin_o));
endmodule // tto_port_monitor

bind tto_port tto_port_monitor u_mon (.*);

// >>> tb/tto_frontend_model.sv
// Front-end readout model
module tto_frontend_model
#(
   parameter logic [7:0] STRAP_ID = 8'ha5   // Arbitrary board strap value
)
(
   input  logic       clk_i,
   input  logic       stall_i,
   input  logic       deskewed_clock_one_o,
   input  logic       trigger_accept_out_o,
   input  logic       event_count_reset_out_o,
   input  logic       broadcast_strobe_one_o,
   input  logic       broadcast_strobe_two_o,
   input  logic [7:2] broadcast_o,
   input  logic       bunch_count_strobe_o,
   input  logic       event_low_word_strobe_o,
   input  logic       event_high_word_strobe_o,
   input  logic [11:0] counter_output_bus_o,
   input  logic       data_out_strobe_o,
   input  logic [7:0] data_out_o,
   input  logic [7:0] sub_address_bus_o,
   input  logic       sub_address_bus_oe_o,
   input  logic [3:0] data_qualifier_o,
   input  logic       single_error_strobe_o,
   input  logic       prom_enable_reset_pin_o,
   input  logic       prom_enable_reset_pin_oe_o,
   output logic       data_hold_i,
   output logic [7:0] sub_address_bus_i,
   output logic       prom_enable_reset_pin_i
);
   logic [2:0]  dly = 3'h0;
   logic        dc1_q = 1'b0;
   logic        smp;
   logic [11:0] bunch_word, lo_word, hi_word;
   logic [5:0]  bc_val;
   logic [19:0] words [16];
   int          ticks, trig_tick, evres_tick, bc1_tick, bc2_tick;
   int          n_bunch, n_lo, n_hi, n_err, n_word;

   // Stall as commanded
   assign data_hold_i = stall_i;
   assign sub_address_bus_i = sub_address_bus_oe_o ? sub_address_bus_o : STRAP_ID;
   assign prom_enable_reset_pin_i = prom_enable_reset_pin_oe_o ? prom_enable_reset_pin_o : 1'b1;
   assign smp = dly[2];

   // Sample three cycles late to avoid racing the port
   // sample on clock one
   always @(posedge clk_i)
   begin
      dc1_q <= deskewed_clock_one_o;
      dly <= {dly[1:0], deskewed_clock_one_o & ~dc1_q};
      if (deskewed_clock_one_o && !dc1_q)
         ticks <= ticks + 1;
      if (smp)
      begin
         if (trigger_accept_out_o) trig_tick <= ticks;
         if (event_count_reset_out_o) evres_tick <= ticks;
         if (broadcast_strobe_one_o) {bc1_tick, bc_val[3:0]} <= {ticks, broadcast_o[5:2]};
         if (broadcast_strobe_two_o) {bc2_tick, bc_val[5:4]} <= {ticks, broadcast_o[7:6]};
         if (bunch_count_strobe_o) {n_bunch, bunch_word} <= {n_bunch + 1, counter_output_bus_o};
         if (event_low_word_strobe_o) {n_lo, lo_word} <= {n_lo + 1, counter_output_bus_o};
         if (event_high_word_strobe_o) {n_hi, hi_word} <= {n_hi + 1, counter_output_bus_o};
         if (single_error_strobe_o) n_err <= n_err + 1;
         if (data_out_strobe_o) n_word <= n_word + 1;
         if (data_out_strobe_o) words[n_word % 16] <= {data_qualifier_o, sub_address_bus_o, data_out_o};
      end
   end
endmodule // tto_frontend_model

// >>> tb/testbench.sv
// Self-checking bench
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_i = 0, rst_i = 1, ref_clock_i = 0, lock_i = 1, serial_b_en_i = 1, serial_b_i = 0;
   logic trigger_i = 0, event_reset_i = 0, bunch_reset_i = 0, broadcast_valid_i = 0;
   logic single_error_i = 0, double_error_i = 0, iac_valid_i = 0, stall_i = 0;
   logic [7:0]  control_i = 8'hfb, coarse_delay_i = 8'h00, iac_data_i = 8'h00, iac_subaddr_i = 8'h00;
   logic [3:0]  fine_delay_one_i = 4'h2, fine_delay_two_i = 4'h5, iac_qual_i = 4'h0;
   logic [7:2]  broadcast_i = 6'h00;
   logic [11:0] bunch_count_i = 12'habc;
   logic [23:0] event_count_i = 24'h123456;
   wire  [11:0] counter_output_bus_o;
   wire  [7:2]  broadcast_o;
   wire  [7:0]  data_out_o, sub_address_bus_o, sub_address_bus_i, chip_identifier_upper_o;
   wire  [3:0]  data_qualifier_o;
   wire iac_ready_o, data_hold_i, bunch_count_strobe_o, event_low_word_strobe_o;
   wire event_high_word_strobe_o, trigger_accept_out_o, event_count_reset_out_o;
   wire bunch_count_reset_out_o, broadcast_strobe_one_o, broadcast_strobe_two_o, data_out_oe_o;
   wire sub_address_bus_oe_o, data_out_strobe_o, single_error_strobe_o, double_error_strobe_o;
   wire serial_b_copy_o, receiver_ready_out_o, reference_clock_out_o, deskewed_clock_one_o;
   wire deskewed_clock_two_o, clock_with_trigger_gap_o, prom_enable_reset_pin_o;
   wire prom_enable_reset_pin_oe_o, prom_enable_reset_pin_i, prom_load_enable_o;
   int  fail_count, checked, nb, nl, nh, nw, t0, lat0;

   tto_port uut (.*);
   tto_frontend_model fe (.*);

   // System and reference clocks
   always #2 clk_i = ~clk_i;
   initial #5 forever #32 ref_clock_i = ~ref_clock_i;

   task check_val(input logic [31:0] got, exp);
      checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task wait_ticks(input int n);
      repeat (n) @(posedge fe.smp);
   endtask

   // One-cycle event pulse
   task fire(input logic [3:0] sel);
      {trigger_i, event_reset_i, bunch_reset_i, single_error_i, broadcast_valid_i} <=
         {sel[0], sel[1], sel[1], sel[2], sel[3]};
      @(posedge clk_i);
      {trigger_i, event_reset_i, bunch_reset_i, single_error_i, broadcast_valid_i} <= 5'h00;
   endtask

   // Hold one word until iac_ready_o is high after the first edge, at most 200 more cycles
   task iac_write(input logic [3:0] q, input logic [7:0] s, d);
      int n;
      n = 0;
      {iac_valid_i, iac_qual_i, iac_subaddr_i, iac_data_i} <= {1'b1, q, s, d};
      @(posedge clk_i);
      while (iac_ready_o !== 1'b1 && n < 200)
      begin
         n++;
         @(posedge clk_i);
      end
      iac_valid_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task give_verdict;
      $display("mismatches %0d, comparisons %0d", fail_count, checked);
      if (fail_count == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Hang guard, far beyond an eight microsecond run
   initial
   begin
      #80000;
      fail_count++;
      give_verdict();
   end

   // Main sequence
   initial
   begin
      repeat (10) @(posedge clk_i);
      check_val({prom_enable_reset_pin_oe_o, sub_address_bus_oe_o}, 2'b00);
      rst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      check_val(chip_identifier_upper_o, 8'ha5);
      check_val(prom_load_enable_o, 1'b1);
      check_val({prom_enable_reset_pin_oe_o, prom_enable_reset_pin_i}, 2'b11);
      check_val({receiver_ready_out_o, sub_address_bus_oe_o, data_out_oe_o}, 3'h7);
      repeat (110) @(posedge clk_i);
      check_val({prom_enable_reset_pin_oe_o, prom_enable_reset_pin_i}, 2'b10);
      lock_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      check_val(receiver_ready_out_o, 1'b0);
      lock_i <= 1'b1;
      // Every sequence mode
      for (int m = 0; m < 4; m++)
      begin
         control_i[1:0] <= m[1:0];
         wait_ticks(1);
         nb = fe.n_bunch;
         nl = fe.n_lo;
         nh = fe.n_hi;
         t0 = fe.ticks;
         fire(4'h1);
         wait_ticks(8);
         check_val(fe.n_bunch - nb, m[0]);
         check_val(fe.n_lo - nl, m[1]);
         check_val(fe.n_hi - nh, m[1]);
      end
      lat0 = fe.trig_tick - t0;
      check_val(fe.bunch_word, 12'habc);
      check_val({fe.lo_word, fe.hi_word}, 24'h456123);
      // Coarse delays three and five ticks
      coarse_delay_i <= 8'h53;
      wait_ticks(1);
      t0 = fe.ticks;
      fire(4'h3);
      wait_ticks(12);
      check_val(fe.trig_tick - t0, lat0 + 3);
      check_val(fe.evres_tick, fe.trig_tick);
      broadcast_i <= 6'h35;
      fire(4'h8);
      wait_ticks(12);
      check_val(fe.bc2_tick - fe.bc1_tick, 2);
      check_val(fe.bc_val, 6'h35);
      nb = fe.n_err;
      fire(4'h4);
      wait_ticks(3);
      check_val(fe.n_err - nb, 1);
      // Every defined qualifier code, 0 to 10, through the buffer
      for (int q = 0; q < 11; q++)
      begin
         nw = fe.n_word;
         iac_write(q[3:0], {4'h4, q[3:0]}, {q[3:0], 4'h9});
         wait_ticks(3);
         check_val(fe.words[nw % 16], {q[3:0], 4'h4, q[3:0], q[3:0], 4'h9});
      end
      // Fill while stalled; unknown qualifier dropped
      stall_i <= 1'b1;
      nw = fe.n_word;
      repeat (4) @(posedge clk_i);
      iac_write(4'h0, 8'h5a, 8'h11);
      iac_write(4'hb, 8'h66, 8'h22);
      iac_write(4'ha, 8'ha5, 8'h33);
      check_val(iac_ready_o, 1'b0);
      stall_i <= 1'b0;
      wait_ticks(5);
      check_val(fe.n_word - nw, 2);
      check_val(fe.words[nw % 16], 20'h05a11);
      check_val(fe.words[(nw + 1) % 16], 20'haa533);
      check_val(iac_ready_o, 1'b1);
      control_i <= 8'hc3;
      repeat (2) @(posedge clk_i);
      check_val(sub_address_bus_oe_o, 1'b0);
      control_i <= 8'hfb;
      serial_b_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      check_val(serial_b_copy_o, 1'b1);
      serial_b_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      check_val(serial_b_copy_o, 1'b0);
      serial_b_en_i <= 1'b0;
      serial_b_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      check_val(serial_b_copy_o, 1'b0);
      give_verdict();
   end
endmodule // testbench
